// ==== inc/afc_pkg.sv ====
/*
 * Shared constants for the analog front-end control register bank:
 * register byte addresses, field positions, reset values and bus codes.
 * Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
 */
`default_nettype none

package afc_pkg;

    // Register byte addresses
    localparam logic [31:0] IBUF_CTRL_ADDR  = 32'h4008_3400;
    localparam logic [31:0] REF_CFG_ADDR    = 32'h4008_7834;

    // Register widths
    localparam int          IBUF_CTRL_W     = 16;
    localparam int          REF_CFG_W       = 8;

    // Reset values
    localparam logic [15:0] IBUF_CTRL_RST   = 16'h000f;
    localparam logic [7:0]  REF_CFG_RST     = 8'h00;

    // Input buffer control fields
    localparam int          AZ_DIS_BIT      = 10;
    localparam int          CHOP_POL_LSB    = 8;
    localparam int          CHOP_EN_LSB     = 4;
    localparam int          BUF_PD_LSB      = 2;
    localparam int          BUF_BYP_LSB     = 0;

    // Reference configuration fields
    localparam int          DRV_A_OFF_BIT   = 6;
    localparam int          EXT_REF_BIT     = 3;
    localparam int          DRV_B_OFF_BIT   = 2;
    localparam int          REFBUF_OFF_BIT  = 1;
    localparam int          BANDGAP_OFF_BIT = 0;

    // AHB-Lite codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam logic        HRESP_OKAY      = 1'h0;
    localparam logic [1:0]  WORD_ALIGN      = 2'h0;

endpackage : afc_pkg

`default_nettype wire

// ==== rtl/afc_ahb_slave.sv ====
/*
 * AHB-Lite front end: captures an address phase and turns it into a
 * one-cycle register write or read strobe in the data phase.
 * Assumes single word transfers; answers with zero wait states.
 */
`default_nettype none

module afc_ahb_slave (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    // Data phase strobes
    output logic             wrStb,
    output logic             rdStb,
    output logic [31:0]      accAddr
);

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
    } afc_aph_s;

    afc_aph_s st_r;
    afc_aph_s st_nxt;
    logic     valid;

    // Only whole aligned words are accepted; others complete as no-ops
    assign valid = hsel && hready
                && (htrans == afc_pkg::HTRANS_NONSEQ
                    || htrans == afc_pkg::HTRANS_SEQ)
                && hsize == afc_pkg::HSIZE_WORD
                && haddr[1:0] == afc_pkg::WORD_ALIGN;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.wr   = valid && hwrite;
        st_nxt.rd   = valid && !hwrite;
        if (valid) begin
            st_nxt.addr = haddr;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wrStb   = st_r.wr;
    assign rdStb   = st_r.rd;
    assign accAddr = st_r.addr;

endmodule : afc_ahb_slave

`default_nettype wire

// ==== rtl/afc_field_drv.sv ====
/*
 * Registers one group of control bits towards the analog side so that
 * every control output comes straight from a flip-flop.
 * Assumes the source value is on the same clock.
 */
`default_nettype none

module afc_field_drv #(
    parameter int              W   = 8,
    parameter logic [W-1:0]    RST = '0
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // Value in and out
    input  wire logic [W-1:0]  valIn,
    output logic [W-1:0]       valOut
);

    typedef struct packed {
        logic [W-1:0] val;
    } afc_drv_s;

    afc_drv_s st_r;
    afc_drv_s st_nxt;

    always_comb begin
        st_nxt     = st_r;
        st_nxt.val = valIn;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r.val <= RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign valOut = st_r.val;

endmodule : afc_field_drv

`default_nettype wire

// ==== rtl/afc_regs.sv ====
/*
 * Analog front-end control register bank: input buffer control and
 * reference configuration, reached over AHB-Lite, driving static
 * controls to the ADC input buffers and the reference subsystem.
 * Assumes one AHB-Lite master; the sequencer lives elsewhere.
 */
// Notes on behaviour
// RQ1: Bit 10 high disables auto-zero; resets low.
// RQ2: Bits 9:8 set buffer chop polarity.
// RQ3: Software clears polarity when auto-zero or chopping.
// RQ4: Bits 5:4 enable chopping per side.
// RQ5: Bits 3:2 power down sides; reset 11.
// RQ6: Bits 1:0 bypass sides; reset 11.
// RQ7: Bit 6 powers down reference driver A.
// RQ8: Bit 3 selects external reference source.
// RQ9: Bit 2 powers down reference driver B.
// RQ10: Bit 1 powers down reference buffer.
// RQ11: Bit 0 powers down band gap.
// RQ12: Software keeps sequencer delay below 255 chopping.
// RQ13: Reserved bits store values, drive nothing.
`default_nettype none

module afc_regs (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Input buffer controls
    output logic             autozero_disable,
    output logic [1:0]       chop_polarity_sel,
    output logic [1:0]       chop_enable_sel,
    output logic [1:0]       buffer_powerdown_sel,
    output logic [1:0]       buffer_bypass_sel,
    // Reference controls
    output logic             ref_driver_a_off,
    output logic             external_ref_select,
    output logic             ref_driver_b_off,
    output logic             ref_buffer_off,
    output logic             bandgap_off
);

    localparam int IW = afc_pkg::IBUF_CTRL_W;
    localparam int RW = afc_pkg::REF_CFG_W;
    localparam int AW = IW + RW;

    typedef struct packed {
        logic [IW-1:0] ibufCtrl;
        logic [RW-1:0] refCfg;
        logic [31:0]   rdData;
    } afc_regs_s;

    afc_regs_s   st_r;
    afc_regs_s   st_nxt;
    logic        wrStb;
    logic        rdStb;
    logic [31:0] accAddr;
    logic [AW-1:0] ctrlPack;
    logic [AW-1:0] ctrlOut;

    afc_ahb_slave u_bus (
        .mclk    (mclk),
        .reset   (reset),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hsize   (hsize),
        .hready  (hready),
        .wrStb   (wrStb),
        .rdStb   (rdStb),
        .accAddr (accAddr)
    );

    // Register writes land in the data phase; reads return stored bits,
    // reserved ones included, so software sees exactly what it wrote.
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rdData = '0;
        if (wrStb) begin
            if (accAddr == afc_pkg::IBUF_CTRL_ADDR) begin
                st_nxt.ibufCtrl = hwdata[IW-1:0]; // RQ13
            end else if (accAddr == afc_pkg::REF_CFG_ADDR) begin
                st_nxt.refCfg = hwdata[RW-1:0]; // RQ13
            end
        end
        // Read data is prepared one cycle early from the address phase
        if (hsel && hready && !hwrite
                && hsize == afc_pkg::HSIZE_WORD
                && (htrans == afc_pkg::HTRANS_NONSEQ
                    || htrans == afc_pkg::HTRANS_SEQ)) begin
            if (haddr == afc_pkg::IBUF_CTRL_ADDR) begin
                st_nxt.rdData = {{(32-IW){1'b0}}, st_nxt.ibufCtrl};
            end else if (haddr == afc_pkg::REF_CFG_ADDR) begin
                st_nxt.rdData = {{(32-RW){1'b0}}, st_nxt.refCfg};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r.ibufCtrl <= afc_pkg::IBUF_CTRL_RST; // RQ5 RQ6
            st_r.refCfg   <= afc_pkg::REF_CFG_RST;
            st_r.rdData   <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read data comes from flops; response is tied to OKAY with zero wait states
    assign hrdata    = st_r.rdData;
    assign hreadyout = 1'b1;
    assign hresp     = afc_pkg::HRESP_OKAY;

    // Polarity is passed through as written; the hardware does not police
    // its use with auto-zero or chopping, software must clear it. RQ3
    assign ctrlPack = {st_nxt.ibufCtrl, st_nxt.refCfg};

    afc_field_drv #(
        .W   (AW),
        .RST ({afc_pkg::IBUF_CTRL_RST, afc_pkg::REF_CFG_RST})
    ) u_drv (
        .mclk   (mclk),
        .reset  (reset),
        .valIn  (ctrlPack),
        .valOut (ctrlOut)
    );

    // Reserved bits are simply not routed to any output
    assign autozero_disable = ctrlOut[RW + afc_pkg::AZ_DIS_BIT]; // RQ1
    assign chop_polarity_sel =
        ctrlOut[RW + afc_pkg::CHOP_POL_LSB +: 2]; // RQ2
    assign chop_enable_sel =
        ctrlOut[RW + afc_pkg::CHOP_EN_LSB +: 2]; // RQ4
    assign buffer_powerdown_sel =
        ctrlOut[RW + afc_pkg::BUF_PD_LSB +: 2]; // RQ5
    assign buffer_bypass_sel =
        ctrlOut[RW + afc_pkg::BUF_BYP_LSB +: 2]; // RQ6
    assign ref_driver_a_off    = ctrlOut[afc_pkg::DRV_A_OFF_BIT]; // RQ7
    assign external_ref_select = ctrlOut[afc_pkg::EXT_REF_BIT]; // RQ8
    assign ref_driver_b_off    = ctrlOut[afc_pkg::DRV_B_OFF_BIT]; // RQ9
    assign ref_buffer_off      = ctrlOut[afc_pkg::REFBUF_OFF_BIT]; // RQ10
    assign bandgap_off         = ctrlOut[afc_pkg::BANDGAP_OFF_BIT]; // RQ11

    // Stored words carry reserved bits too, so read-back matches writes
    ibuf_store_a : assert property ( // RQ13
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |=> st_r.ibufCtrl == $past(hwdata[IW-1:0]))
        else $error("Input buffer register did not store the word");

    ref_store_a : assert property ( // RQ13
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> st_r.refCfg == $past(hwdata[RW-1:0]))
        else $error("Reference register did not store the word");

    // Each control takes its field one edge after the write data phase
    az_write_a : assert property ( // RQ1
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |=> autozero_disable == $past(hwdata[afc_pkg::AZ_DIS_BIT]))
        else $error("Auto-zero control did not take written bit");

    polarity_write_a : assert property ( // RQ2
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |=> chop_polarity_sel
            == $past(hwdata[afc_pkg::CHOP_POL_LSB +: 2]))
        else $error("Chop polarity did not take written field");

    chop_write_a : assert property ( // RQ4
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |=> chop_enable_sel == $past(hwdata[afc_pkg::CHOP_EN_LSB +: 2]))
        else $error("Chop enable did not take written field");

    pd_write_a : assert property ( // RQ5
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |=> buffer_powerdown_sel
            == $past(hwdata[afc_pkg::BUF_PD_LSB +: 2]))
        else $error("Buffer power-down did not take written field");

    bypass_write_a : assert property ( // RQ6
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |=> buffer_bypass_sel == $past(hwdata[afc_pkg::BUF_BYP_LSB +: 2]))
        else $error("Bypass did not take written field");

    drv_a_write_a : assert property ( // RQ7
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> ref_driver_a_off == $past(hwdata[afc_pkg::DRV_A_OFF_BIT]))
        else $error("Driver A power-down did not take written bit");

    ext_ref_write_a : assert property ( // RQ8
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> external_ref_select == $past(hwdata[afc_pkg::EXT_REF_BIT]))
        else $error("Reference source select did not take written bit");

    drv_b_write_a : assert property ( // RQ9
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> ref_driver_b_off == $past(hwdata[afc_pkg::DRV_B_OFF_BIT]))
        else $error("Driver B power-down did not take written bit");

    refbuf_write_a : assert property ( // RQ10
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> ref_buffer_off == $past(hwdata[afc_pkg::REFBUF_OFF_BIT]))
        else $error("Reference buffer power-down did not take written bit");

    bandgap_write_a : assert property ( // RQ11
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> bandgap_off == $past(hwdata[afc_pkg::BANDGAP_OFF_BIT]))
        else $error("Band gap power-down did not take written bit");

    refcfg_write_a : assert property ( // RQ7 RQ8 RQ9
        @(posedge mclk) disable iff (reset)
        wrStb && accAddr == afc_pkg::REF_CFG_ADDR
        |=> {ref_driver_a_off, external_ref_select, ref_driver_b_off}
            == {$past(hwdata[afc_pkg::DRV_A_OFF_BIT]),
                $past(hwdata[afc_pkg::EXT_REF_BIT]),
                $past(hwdata[afc_pkg::DRV_B_OFF_BIT])})
        else $error("Reference controls did not take written bits");

    // Controls are static: only a write to their register moves them
    az_hold_a : assert property ( // RQ1
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR)
        |=> $stable(autozero_disable))
        else $error("Auto-zero control changed without a write");

    polarity_hold_a : assert property ( // RQ2
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR)
        |=> $stable(chop_polarity_sel))
        else $error("Chop polarity changed without a write");

    chop_hold_a : assert property ( // RQ4
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR)
        |=> $stable(chop_enable_sel))
        else $error("Chop enable changed without a write");

    pd_hold_a : assert property ( // RQ5
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR)
        |=> $stable(buffer_powerdown_sel))
        else $error("Buffer power-down changed without a write");

    bypass_hold_a : assert property ( // RQ6
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::IBUF_CTRL_ADDR)
        |=> $stable(buffer_bypass_sel))
        else $error("Bypass changed without a write");

    drv_a_hold_a : assert property ( // RQ7
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::REF_CFG_ADDR)
        |=> $stable(ref_driver_a_off))
        else $error("Driver A power-down changed without a write");

    ext_ref_hold_a : assert property ( // RQ8
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::REF_CFG_ADDR)
        |=> $stable(external_ref_select))
        else $error("Reference source changed without a write");

    drv_b_hold_a : assert property ( // RQ9
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::REF_CFG_ADDR)
        |=> $stable(ref_driver_b_off))
        else $error("Driver B power-down changed without a write");

    ref_hold_a : assert property ( // RQ10 RQ11
        @(posedge mclk) disable iff (reset)
        !(wrStb && accAddr == afc_pkg::REF_CFG_ADDR)
        |=> $stable({ref_buffer_off, bandgap_off}))
        else $error("Reference power-down changed without a write");

    // Reset values hold during reset and at the first edge after it
    reset_value_a : assert property ( // RQ1 RQ5 RQ6 RQ11
        @(posedge mclk)
        $fell(reset) |-> buffer_bypass_sel == 2'h3
            && buffer_powerdown_sel == 2'h3 && !autozero_disable
            && !bandgap_off)
        else $error("Wrong control values after reset");

    ibuf_reset_a : assert property ( // RQ2 RQ4
        @(posedge mclk)
        $fell(reset) |-> chop_polarity_sel == 2'h0
            && chop_enable_sel == 2'h0)
        else $error("Chop controls not cleared after reset");

    ref_reset_a : assert property ( // RQ7 RQ8 RQ9 RQ10
        @(posedge mclk)
        $fell(reset) |-> !ref_driver_a_off && !external_ref_select
            && !ref_driver_b_off && !ref_buffer_off)
        else $error("Reference controls not cleared after reset");

    pd_in_reset_a : assert property ( // RQ5 RQ6
        @(posedge mclk)
        reset |=> buffer_powerdown_sel == 2'h3
            && buffer_bypass_sel == 2'h3)
        else $error("Buffers not powered down and bypassed in reset");

    ref_in_reset_a : assert property ( // RQ7 RQ8 RQ9 RQ10 RQ11
        @(posedge mclk)
        reset |=> {ref_driver_a_off, external_ref_select, ref_driver_b_off,
                   ref_buffer_off, bandgap_off} == 5'h00)
        else $error("Reference controls not cleared in reset");

    // Read data stands only in a read data phase, zero elsewhere
    read_back_a : assert property ( // RQ13
        @(posedge mclk) disable iff (reset)
        rdStb && accAddr == afc_pkg::IBUF_CTRL_ADDR
        |-> hrdata == {16'h0000, st_r.ibufCtrl})
        else $error("Input buffer register read back wrong");

    ref_read_back_a : assert property ( // RQ13
        @(posedge mclk) disable iff (reset)
        rdStb && accAddr == afc_pkg::REF_CFG_ADDR
        |-> hrdata == {{(32-RW){1'b0}}, st_r.refCfg})
        else $error("Reference register read back wrong");

    unmapped_rd_a : assert property ( // RQ13
        @(posedge mclk) disable iff (reset)
        rdStb && accAddr != afc_pkg::IBUF_CTRL_ADDR
            && accAddr != afc_pkg::REF_CFG_ADDR
        |-> hrdata == 32'h0000_0000)
        else $error("Unmapped read returned nonzero data");

    hrdata_idle_a : assert property ( // RQ13
        @(posedge mclk) disable iff (reset)
        !rdStb |-> hrdata == 32'h0000_0000)
        else $error("Read data present outside a read data phase");

endmodule : afc_regs

`default_nettype wire

// ==== test/afc_regs_tb.sv ====
/*
 * Self-checking bench for the analog front-end control register bank.
 * Assumes afc_pkg is compiled first; the bench is the only bus master.
 */
`default_nettype none

module afc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] IB = afc_pkg::IBUF_CTRL_ADDR;
    localparam logic [31:0] RF = afc_pkg::REF_CFG_ADDR;
    // Sequencer gap that software keeps while chopping; lives elsewhere
    localparam int          SEQ_GAP = 254;

    logic        mclk   = 1'b0;
    logic        reset  = 1'b1;
    logic        hsel   = 1'b0;
    logic [31:0] haddr  = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize  = afc_pkg::HSIZE_WORD;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        azDis, drvA, extRef, drvB, refBuf, bgOff;
    logic [1:0]  chopPol, chopEn, bufPd, bufByp;
    int          miscompares = 0;
    int          testsRun    = 0;
    logic [32:0] expQ[$];
    logic        rdPend = 1'b0;
    // Model for reads (blocking) and shadow for the output monitor (NBA)
    logic [15:0] mIb = 16'h000f;
    logic [7:0]  mRf = 8'h00;
    logic [15:0] eIb = 16'h000f;
    logic [7:0]  eRf = 8'h00;

    always #5 mclk = ~mclk;

    afc_regs uut (
        .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .autozero_disable(azDis), .chop_polarity_sel(chopPol),
        .chop_enable_sel(chopEn), .buffer_powerdown_sel(bufPd),
        .buffer_bypass_sel(bufByp), .ref_driver_a_off(drvA),
        .external_ref_select(extRef), .ref_driver_b_off(drvB),
        .ref_buffer_off(refBuf), .bandgap_off(bgOff)
    );

    task automatic note(input logic bad, input string msg);
        testsRun++;
        if (bad) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : note

    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        note(got !== exp, "read data or response");
    endtask : cmp_rd

    task automatic cmp_ctrl(input logic [8:0] got, input logic [8:0] exp);
        note(got !== exp, "control outputs");
    endtask : cmp_ctrl

    // Outputs move only at the edge that ends a write data phase
    always @(posedge mclk) begin
        if (!reset) begin
            cmp_ctrl({azDis, chopPol, chopEn, bufPd, bufByp},
                     {eIb[10:8], eIb[5:0]});
            cmp_ctrl({4'h0, drvA, extRef, drvB, refBuf, bgOff},
                     {4'h0, eRf[6], eRf[3:0]});
            if (rdPend && hreadyout) begin
                if (expQ.size() == 0)
                    note(1'b1, "read with no expectation");
                else
                    cmp_rd({hresp, hrdata}, expQ.pop_front());
            end
        end
        rdPend <= !reset && hsel && htrans == afc_pkg::HTRANS_NONSEQ
                  && !hwrite && hreadyout;
    end

    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= afc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        if (a == IB && d[5:4] != 2'h0 && SEQ_GAP >= 255)
            d[5:4] = 2'h0;
        if (a == IB && (!d[10] || d[5:4] != 2'h0))
            d[9:8] = 2'h0;
        bus(a, 1'b1, d);
        if (a == IB) begin
            mIb = d[15:0];
            eIb <= d[15:0];
        end else if (a == RF) begin
            mRf = d[7:0];
            eRf <= d[7:0];
        end
    endtask : wr

    task automatic rd(input logic [31:0] a);
        expQ.push_back({afc_pkg::HRESP_OKAY,
                        a == IB ? {16'h0000, mIb} :
                        a == RF ? {24'h00_0000, mRf} : 32'h0000_0000});
        bus(a, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    initial begin
        #100us;
        note(1'b1, "watchdog expired");
        give_verdict();
    end

    initial begin
        logic [31:0] a;
        void'($urandom(20));
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(IB);
        rd(RF);
        // Every code of every two-bit field, polarity only where legal
        for (int v = 0; v < 4; v++) begin
            wr(IB, {21'h0, 1'b1, v[1:0], 2'h0, 2'h0, v[1:0], v[1:0]});
            rd(IB);
            wr(IB, {21'h0, 1'b0, 2'h0, 2'h0, v[1:0], v[1:0], v[1:0]});
            rd(IB);
        end
        for (int i = 0; i < 8; i++) begin
            wr(RF, 32'h0000_0001 << i);
            rd(RF);
        end
        // Random write and read-back pairs, each transfer alone on the bus; upper data bits random too
        repeat (60) begin
            a = $urandom_range(1) ? IB : RF;
            wr(a, $urandom);
            rd(a);
        end
        // Unmapped places: writes ignored, reads zero
        wr(IB + 32'h0000_0004, $urandom);
        rd(IB + 32'h0000_0004);
        wr(RF + 32'h0000_0004, $urandom);
        rd(RF + 32'h0000_0004);
        // Reset in mid-run restores every reset value
        reset <= 1'b1;
        mIb = 16'h000f;
        mRf = 8'h00;
        eIb <= 16'h000f;
        eRf <= 8'h00;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(IB);
        rd(RF);
        repeat (2) @(posedge mclk);
        if (expQ.size() != 0)
            note(1'b1, "reads left without an answer");
        give_verdict();
    end
endmodule : afc_regs_tb

`default_nettype wire
